/* design/pin_sync_bank.sv */
// two-stage synchroniser bank for asynchronous pins
`timescale 1ns/1ns
module pin_sync_bank #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] firstStage;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          firstStage[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          firstStage[i] <= asyncIn[i];
          syncOut[i] <= firstStage[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync_bank

/* design/ulpi_phy_latch_debug_uart_regs.sv */
// ulpi phy event latch, line monitor, spare byte and uart route registers
`timescale 1ns/1ns
// What this block does
// [RULE1] unmasked source change sets its event flag
// [RULE2] reading event flags clears all of them
// [RULE3] entering low power clears all flags
// [RULE4] report source state in receive command bytes
// [RULE5] flag map bits 4..0, upper zero
// [RULE6] line monitor shows line state bits 1:0
// [RULE7] spare byte, reset zero, no side effects
// [RULE8] write base, set plus one, clear plus two
// [RULE9] uart routes act only with uart select
// [RULE10] link sets select before route enables
// [RULE11] uart mode stops ulpi protocol service
// [RULE12] stop or chip select ends uart mode
// [RULE13] rx route: d plus to data1
// [RULE14] tx route: data0 to d minus
// [RULE15] uart exit clears both route enables
// [RULE16] link never writes reserved control bits
// [RULE17] rise and fall masks select counted edges
// [RULE18] event beats a simultaneous clearing read
module ulpi_phy_latch_debug_uart_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chipSel,
  input wire logic stp,
  input wire logic [ulpi_regs_pkg::DATA_W-1:0] dataIn,
  output logic [ulpi_regs_pkg::DATA_W-1:0] dataOut,
  output logic [ulpi_regs_pkg::DATA_W-1:0] dataOe,
  output logic dir,
  output logic nxt,
  input wire logic id_pin_grounded,
  input wire logic session_end_comparator,
  input wire logic session_ok_comparator,
  input wire logic bus_power_ok_comparator,
  input wire logic downstream_detach_detector,
  input wire logic line_level_bit1,
  input wire logic line_level_bit0,
  input wire logic dpIn,
  output logic dmOut,
  output logic dmOe,
  input wire logic [ulpi_regs_pkg::SRC_W-1:0] riseEnable,
  input wire logic [ulpi_regs_pkg::SRC_W-1:0] fallEnable,
  input wire logic uartSelect,
  input wire logic lowPowerEntry,
  output logic uartActive
);
  import ulpi_regs_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ACK, S_WDATA, S_WSTOP, S_RTURN, S_RDATA, S_RBACK,
    S_XTURN, S_XDATA, S_XBACK, S_UART
  } ulpi_state_e;

  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncPins;
  logic [SRC_W-1:0] srcNow;
  logic [SRC_W-1:0] srcPrev;
  logic [LINE_W-1:0] lineNow;
  logic [LINE_W-1:0] linePrev;
  logic dpNow;
  logic chipOn;

  ulpi_state_e state, next_state;
  logic [ADDR_W-1:0] addr, next_addr;
  logic isWrite, next_isWrite;
  logic [SRC_W-1:0] eventFlags, next_eventFlags;
  logic [DATA_W-1:0] spare, next_spare;
  logic [DATA_W-1:0] uartCtrl, next_uartCtrl;
  logic rxPending, next_rxPending;
  logic [DATA_W-1:0] next_dataOut;
  logic [DATA_W-1:0] next_dataOe;
  logic next_dir;
  logic next_nxt;
  logic next_dmOut;
  logic next_dmOe;
  logic next_uartActive;

  logic [SRC_W-1:0] srcEvents;
  logic lineChange;
  logic uartMode;
  logic flagsRead;

  assign syncIn = {chipSel, dpIn, line_level_bit1, line_level_bit0, id_pin_grounded,
                   session_end_comparator, session_ok_comparator,
                   bus_power_ok_comparator, downstream_detach_detector};

  pin_sync_bank #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn(syncIn),
    .syncOut(syncPins)
  );

  assign srcNow = syncPins[SRC_W-1:0];
  assign lineNow = syncPins[SYNC_LINE_LSB +: LINE_W];
  assign dpNow = syncPins[SYNC_DP_BIT];
  assign chipOn = syncPins[SYNC_CHIP_SEL_BIT];

  // write, set or clear access on a base address
  function automatic logic [DATA_W-1:0] rw_update(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wdata,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base
  );
    logic [DATA_W-1:0] res;
    res = old;
    if (a == base) begin
      res = wdata;
    end else if (a == ADDR_W'(base + SET_OFFS)) begin
      res = old | wdata;
    end else if (a == ADDR_W'(base + CLR_OFFS)) begin
      res = old & ~wdata;
    end
    return res;
  endfunction : rw_update

  // read accepted on base, set or clear address
  function automatic logic in_rw_window(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base
  );
    return (a >= base) && (a <= ADDR_W'(base + CLR_OFFS));
  endfunction : in_rw_window

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] res;
    res = '0;
    if (a == EVENT_FLAGS_ADDR) begin
      // [RULE5] reserved bits zero
      res = {{(DATA_W-SRC_W){1'b0}}, eventFlags};
    end else if (a == LINE_MON_ADDR) begin
      // [RULE6] live line state
      res = {{(DATA_W-LINE_W){1'b0}}, lineNow};
    end else if (in_rw_window(a, SPARE_BASE)) begin
      res = spare;
    end else if (in_rw_window(a, UART_CTRL_BASE)) begin
      res = uartCtrl;
    end
    return res;
  endfunction : read_mux

  function automatic logic [DATA_W-1:0] rx_cmd_byte(
    input logic [SRC_W-1:0] src,
    input logic [LINE_W-1:0] line
  );
    logic [DATA_W-1:0] res;
    logic [1:0] vb;
    res = '0;
    if (src[BUS_POWER_OK_BIT]) begin
      vb = VBUS_POWER_OK;
    end else if (src[SESSION_OK_BIT]) begin
      vb = VBUS_SESSION_OK;
    end else if (src[SESSION_END_BIT]) begin
      vb = VBUS_BELOW_END;
    end else begin
      vb = VBUS_END_TO_OK;
    end
    res[RXCMD_LINE_LSB +: LINE_W] = line;
    res[RXCMD_VBUS_LSB +: 2] = vb;
    res[RXCMD_ID_BIT] = src[ID_GROUND_BIT];
    return res;
  endfunction : rx_cmd_byte

  // [RULE17] edge selection by masks
  assign srcEvents = (srcNow & ~srcPrev & riseEnable) | (~srcNow & srcPrev & fallEnable);
  assign lineChange = lineNow != linePrev;
  // [RULE9] routes act only under uart select
  assign uartMode = uartSelect && (uartCtrl[RX_ROUTE_BIT] || uartCtrl[TX_ROUTE_BIT]);
  // [RULE2] clearing read when flags are driven out
  assign flagsRead = (state == S_RTURN) && (addr == EVENT_FLAGS_ADDR);

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_isWrite = isWrite;
    next_spare = spare;
    next_uartCtrl = uartCtrl;
    next_rxPending = rxPending;
    next_eventFlags = eventFlags;
    next_dataOut = '0;
    next_dataOe = '0;
    next_dir = 1'b0;
    next_nxt = 1'b0;
    next_dmOut = 1'b0;
    next_dmOe = 1'b0;
    // [RULE2] clear all on read
    // [RULE3] clear all on low power
    if (flagsRead || lowPowerEntry) begin
      next_eventFlags = '0;
    end
    // [RULE1] hardware sets flags
    // [RULE18] set wins over clear
    next_eventFlags = next_eventFlags | srcEvents;
    // [RULE4] queue a receive command on change
    if ((|srcEvents) || lineChange) begin
      next_rxPending = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (uartMode) begin
          // [RULE11] ulpi service stops
          next_state = S_UART;
        end else if (!stp && (dataIn[7:6] == CMD_REG_WRITE || dataIn[7:6] == CMD_REG_READ)) begin
          next_addr = dataIn[ADDR_W-1:0];
          next_isWrite = dataIn[7:6] == CMD_REG_WRITE;
          next_state = S_ACK;
        end else if (rxPending) begin
          next_state = S_XTURN;
        end
      end
      S_ACK: begin
        next_state = isWrite ? S_WDATA : S_RTURN;
      end
      S_WDATA: begin
        // [RULE7] spare byte has no side effect
        // [RULE8] write, set and clear addresses
        next_spare = rw_update(spare, dataIn, addr, SPARE_BASE);
        next_uartCtrl = rw_update(uartCtrl, dataIn, addr, UART_CTRL_BASE) & UART_CTRL_WRITABLE;
        next_state = S_WSTOP;
      end
      S_WSTOP: begin
        if (stp) begin
          next_state = S_IDLE;
        end
      end
      S_RTURN: begin
        next_state = S_RDATA;
      end
      S_RDATA: begin
        next_state = S_RBACK;
      end
      S_RBACK: begin
        next_state = S_IDLE;
      end
      S_XTURN: begin
        next_rxPending = ((|srcEvents) || lineChange);
        next_state = S_XDATA;
      end
      S_XDATA: begin
        next_state = S_XBACK;
      end
      S_XBACK: begin
        next_state = S_IDLE;
      end
      S_UART: begin
        // [RULE12] stop ends uart mode
        if (stp || !uartMode) begin
          // [RULE15] route enables self clear
          next_uartCtrl[RX_ROUTE_BIT] = 1'b0;
          next_uartCtrl[TX_ROUTE_BIT] = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    // output decode from the coming state
    case (next_state)
      S_ACK, S_WDATA: begin
        next_nxt = 1'b1;
      end
      S_RTURN, S_XTURN: begin
        next_dir = 1'b1;
      end
      S_RDATA: begin
        next_dir = 1'b1;
        next_dataOe = '1;
        next_dataOut = read_mux(addr);
      end
      S_XDATA: begin
        next_dir = 1'b1;
        next_dataOe = '1;
        next_dataOut = rx_cmd_byte(srcNow, lineNow);
      end
      S_UART: begin
        // [RULE13] d plus to data1
        if (next_uartCtrl[RX_ROUTE_BIT]) begin
          next_dataOe[UART_RX_DATA_BIT] = 1'b1;
          next_dataOut[UART_RX_DATA_BIT] = dpNow;
        end
        // [RULE14] data0 to d minus
        if (next_uartCtrl[TX_ROUTE_BIT]) begin
          next_dmOe = 1'b1;
          next_dmOut = dataIn[UART_TX_DATA_BIT];
        end
      end
      default: begin
        next_dir = 1'b0;
      end
    endcase
    next_uartActive = next_state == S_UART;
    // [RULE12] chip select hardware reset
    if (!chipOn) begin
      next_state = S_IDLE;
      next_eventFlags = EVENT_FLAGS_RESET[SRC_W-1:0];
      next_spare = SPARE_RESET;
      next_uartCtrl = UART_CTRL_RESET;
      next_rxPending = 1'b0;
      next_dataOut = '0;
      next_dataOe = '0;
      next_dir = 1'b0;
      next_nxt = 1'b0;
      next_dmOut = 1'b0;
      next_dmOe = 1'b0;
      next_uartActive = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      addr <= '0;
      isWrite <= 1'b0;
      eventFlags <= EVENT_FLAGS_RESET[SRC_W-1:0];
      spare <= SPARE_RESET;
      uartCtrl <= UART_CTRL_RESET;
      rxPending <= 1'b0;
      srcPrev <= '0;
      linePrev <= '0;
      dataOut <= '0;
      dataOe <= '0;
      dir <= 1'b0;
      nxt <= 1'b0;
      dmOut <= 1'b0;
      dmOe <= 1'b0;
      uartActive <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      isWrite <= next_isWrite;
      eventFlags <= next_eventFlags;
      spare <= next_spare;
      uartCtrl <= next_uartCtrl;
      rxPending <= next_rxPending;
      srcPrev <= srcNow;
      linePrev <= lineNow;
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      dir <= next_dir;
      nxt <= next_nxt;
      dmOut <= next_dmOut;
      dmOe <= next_dmOe;
      uartActive <= next_uartActive;
    end
  end
endmodule : ulpi_phy_latch_debug_uart_regs

/* design/ulpi_regs_pkg.sv */
// constants for the ulpi latch, debug, spare and uart route registers
package ulpi_regs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int SRC_W = 5;
  localparam int LINE_W = 2;
  // register base addresses
  localparam logic [5:0] EVENT_FLAGS_ADDR = 6'h14;
  localparam logic [5:0] LINE_MON_ADDR = 6'h15;
  localparam logic [5:0] SPARE_BASE = 6'h16;
  localparam logic [5:0] UART_CTRL_BASE = 6'h19;
  // offsets from a read/write base
  localparam logic [5:0] SET_OFFS = 6'h01;
  localparam logic [5:0] CLR_OFFS = 6'h02;
  // reset values
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [7:0] UART_CTRL_RESET = 8'h00;
  // source bit positions in status, masks and event flags
  localparam int ID_GROUND_BIT = 4;
  localparam int SESSION_END_BIT = 3;
  localparam int SESSION_OK_BIT = 2;
  localparam int BUS_POWER_OK_BIT = 1;
  localparam int DOWNSTREAM_DETACH_BIT = 0;
  // uart route control fields
  localparam int RX_ROUTE_BIT = 3;
  localparam int TX_ROUTE_BIT = 2;
  localparam logic [7:0] UART_CTRL_WRITABLE = 8'h0C;
  // uart data pins
  localparam int UART_RX_DATA_BIT = 1;
  localparam int UART_TX_DATA_BIT = 0;
  // transmit command codes in data[7:6]
  localparam logic [1:0] CMD_REG_WRITE = 2'b10;
  localparam logic [1:0] CMD_REG_READ = 2'b11;
  // receive command byte fields
  localparam int RXCMD_LINE_LSB = 0;
  localparam int RXCMD_VBUS_LSB = 2;
  localparam int RXCMD_ID_BIT = 6;
  localparam logic [1:0] VBUS_BELOW_END = 2'b00;
  localparam logic [1:0] VBUS_END_TO_OK = 2'b01;
  localparam logic [1:0] VBUS_SESSION_OK = 2'b10;
  localparam logic [1:0] VBUS_POWER_OK = 2'b11;
  // synchroniser
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_W = 9;
  localparam int SYNC_LINE_LSB = 5;
  localparam int SYNC_DP_BIT = 7;
  localparam int SYNC_CHIP_SEL_BIT = 8;
endpackage : ulpi_regs_pkg

/* sim/tb_ulpi_phy_latch_debug_uart_regs.sv */
// self-checking bench for the ulpi latch, monitor, spare and uart block
`timescale 1ns/1ns
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin numErrors++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module tb_ulpi_phy_latch_debug_uart_regs;
  import ulpi_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic chipSel = 1'b1;
  logic dpIn = 1'b0;
  logic uartSelect = 1'b0;
  logic lowPower = 1'b0;
  logic [SRC_W-1:0] src = '0;
  logic [SRC_W-1:0] riseEn = '1;
  logic [SRC_W-1:0] fallEn = '1;
  logic [LINE_W-1:0] line = '0;
  logic [DATA_W-1:0] dataIn, dataOut, dataOe;
  logic stp, dir, nxt, dmOut, dmOe, uartActive;
  int numErrors = 0;
  int testsRun = 0;
  always #2 clk = ~clk;
  ulpi_phy_latch_debug_uart_regs dut_u (.clk, .rst_b, .chipSel, .stp, .dataIn, .dataOut,
    .dataOe, .dir, .nxt, .id_pin_grounded(src[ID_GROUND_BIT]),
    .session_end_comparator(src[SESSION_END_BIT]), .session_ok_comparator(src[SESSION_OK_BIT]),
    .bus_power_ok_comparator(src[BUS_POWER_OK_BIT]),
    .downstream_detach_detector(src[DOWNSTREAM_DETACH_BIT]), .line_level_bit1(line[1]),
    .line_level_bit0(line[0]), .dpIn, .dmOut, .dmOe, .riseEnable(riseEn), .fallEnable(fallEn),
    .uartSelect, .lowPowerEntry(lowPower), .uartActive);
  ulpi_link_model link_u (.clk, .dir, .nxt, .dataOut, .stp, .dataIn);
  function automatic logic [7:0] expFlags(input logic [4:0] p, input logic [4:0] n);
    return {3'b000, (~p & n & riseEn) | (p & ~n & fallEn)};
  endfunction : expFlags
  function automatic logic [7:0] expCmd(input logic [4:0] s, input logic [1:0] l);
    logic [1:0] v;
    v = s[BUS_POWER_OK_BIT] ? VBUS_POWER_OK : s[SESSION_OK_BIT] ? VBUS_SESSION_OK :
      s[SESSION_END_BIT] ? VBUS_BELOW_END : VBUS_END_TO_OK;
    return {1'b0, s[ID_GROUND_BIT], 2'b00, v, l};
  endfunction : expCmd
  task automatic completeRun();
    if (numErrors == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : completeRun
  task automatic hang(input bit ok);
    if (!ok) begin
      numErrors++;
      completeRun();
    end
  endtask : hang
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    link_u.regRead(a, d, ok);
    hang(ok);
    `CHK(d, e)
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bit ok;
    link_u.regWrite(a, d, ok);
    hang(ok);
  endtask : wr
  initial begin
    logic [4:0] prev;
    logic [7:0] r, s, e;
    bit ok;
    void'($urandom(4));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd(EVENT_FLAGS_ADDR, EVENT_FLAGS_RESET);
    rd(SPARE_BASE, SPARE_RESET);
    rd(6'h20, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'hFF : 8'($urandom);
      s = 8'($urandom);
      e = 8'($urandom);
      wr(SPARE_BASE, r);
      rd(SPARE_BASE + SET_OFFS, r);
      wr(SPARE_BASE + SET_OFFS, s);
      rd(SPARE_BASE + CLR_OFFS, r | s);
      wr(SPARE_BASE + CLR_OFFS, e);
      rd(SPARE_BASE, (r | s) & ~e);
    end
    for (int i = 0; i < 4; i++) begin
      line = i[1:0];
      repeat (12) @(negedge clk);
      rd(LINE_MON_ADDR, {6'h00, line});
    end
    rd(SPARE_BASE, (r | s) & ~e);
    prev = src;
    for (int i = 0; i < 24; i++) begin
      riseEn = (i == 0) ? 5'h00 : 5'($urandom);
      fallEn = (i == 0) ? 5'h00 : 5'($urandom);
      src = (i == 0) ? ~prev : 5'($urandom);
      e = expFlags(prev, src);
      if (e != 8'h00) begin
        for (int k = 0; k < 12 && dir !== 1'b1; k++) @(negedge clk);
        hang(dir === 1'b1);
        @(negedge clk);
        `CHK(dataOut, expCmd(src, line))
      end
      repeat (8) @(negedge clk);
      rd(EVENT_FLAGS_ADDR, e);
      rd(EVENT_FLAGS_ADDR, 8'h00);
      prev = src;
    end
    riseEn = '1;
    fallEn = '1;
    fork
      rd(EVENT_FLAGS_ADDR, 8'h00);
      begin
        @(negedge clk);
        src = ~src;
      end
    join
    repeat (8) @(negedge clk);
    rd(EVENT_FLAGS_ADDR, 8'h1F);
    src = ~src;
    repeat (12) @(negedge clk);
    lowPower = 1'b1;
    @(negedge clk);
    lowPower = 1'b0;
    rd(EVENT_FLAGS_ADDR, 8'h00);
    wr(UART_CTRL_BASE, 8'h0C);
    repeat (4) @(negedge clk);
    `CHK(uartActive, 1'b0)
    rd(UART_CTRL_BASE + CLR_OFFS, 8'h0C);
    wr(UART_CTRL_BASE + CLR_OFFS, 8'h0C);
    rd(UART_CTRL_BASE + SET_OFFS, 8'h00);
    for (int m = 0; m < 3; m++) begin
      r = (m == 1) ? 8'h08 : (m == 2) ? 8'h04 : 8'h0C;
      uartSelect = 1'b1;
      wr(UART_CTRL_BASE + (m == 1 ? SET_OFFS : 6'h00), r);
      repeat (2) @(negedge clk);
      `CHK(uartActive, 1'b1)
      link_u.regRead(SPARE_BASE, e, ok);
      `CHK(ok, 1'b0)
      for (int b = 0; b < 2; b++) begin
        link_u.drive({7'h00, b[0]});
        dpIn = b[0];
        repeat (4) @(negedge clk);
        `CHK({dmOe, dmOut}, {r[TX_ROUTE_BIT], r[TX_ROUTE_BIT] & b[0]})
        `CHK({dataOe[1], dataOut[1]}, {r[RX_ROUTE_BIT], r[RX_ROUTE_BIT] & b[0]})
      end
      if (m == 0) begin
        link_u.pulseStop();
      end else if (m == 1) begin
        uartSelect = 1'b0;
      end else begin
        chipSel = 1'b0;
        repeat (6) @(negedge clk);
        chipSel = 1'b1;
      end
      repeat (6) @(negedge clk);
      `CHK(uartActive, 1'b0)
      rd(UART_CTRL_BASE, 8'h00);
    end
    completeRun();
  end
endmodule : tb_ulpi_phy_latch_debug_uart_regs

/* sim/ulpi_link_model.sv */
// link side model issuing ulpi register accesses
`timescale 1ns/1ns
module ulpi_link_model (
  input wire logic clk,
  input wire logic dir,
  input wire logic nxt,
  input wire logic [ulpi_regs_pkg::DATA_W-1:0] dataOut,
  output logic stp,
  output logic [ulpi_regs_pkg::DATA_W-1:0] dataIn
);
  import ulpi_regs_pkg::*;
  initial begin
    stp = 1'b0;
    dataIn = 8'h00;
  end
  task automatic waitNxt(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      ok = nxt;
    end
  endtask : waitNxt
  task automatic regWrite(input logic [5:0] addr, input logic [7:0] data, output bit ok);
    @(negedge clk);
    dataIn = {CMD_REG_WRITE, addr};
    waitNxt(ok);
    @(negedge clk);
    dataIn = data;
    @(negedge clk);
    stp = 1'b1;
    dataIn = 8'h00;
    @(negedge clk);
    stp = 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [5:0] addr, output logic [7:0] data, output bit ok);
    data = 8'h00;
    @(negedge clk);
    dataIn = {CMD_REG_READ, addr};
    waitNxt(ok);
    @(negedge clk);
    dataIn = 8'h00;
    if (ok) begin
      @(negedge clk);
      // read byte only counts while the phy owns the bus
      data = dataOut;
      ok = dir;
      @(negedge clk);
    end
  endtask : regRead
  task automatic drive(input logic [7:0] v);
    @(negedge clk);
    dataIn = v;
  endtask : drive
  task automatic pulseStop();
    @(negedge clk);
    stp = 1'b1;
    @(negedge clk);
    stp = 1'b0;
  endtask : pulseStop
endmodule : ulpi_link_model

/* sim/ulpi_phy_latch_debug_uart_regs_assertions.sv */
// port assertions for the ulpi latch, monitor, spare and uart route block
`timescale 1ns/1ns
module ulpi_regs_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chipSel,
  input wire logic stp,
  input wire logic [ulpi_regs_pkg::DATA_W-1:0] dataIn,
  input wire logic [ulpi_regs_pkg::DATA_W-1:0] dataOut,
  input wire logic [ulpi_regs_pkg::DATA_W-1:0] dataOe,
  input wire logic dir,
  input wire logic nxt,
  input wire logic dpIn,
  input wire logic dmOut,
  input wire logic dmOe,
  input wire logic uartSelect,
  input wire logic uartActive
);
  import ulpi_regs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  uart_no_bus_a: assert property (uartActive |-> !dir && !nxt)
    else $error("bus served in uart mode");
  stp_exit_a: assert property (uartActive && stp |=> !uartActive)
    else $error("stp did not end uart mode");
  select_exit_a: assert property (uartActive && !uartSelect |=> !uartActive)
    else $error("uart mode kept without select");
  chip_quiet_a: assert property (!chipSel [*5] |-> !dir && !uartActive && !dmOe)
    else $error("block active while deselected");
  tx_route_a: assert property (dmOe |-> dmOut == $past(dataIn[UART_TX_DATA_BIT]))
    else $error("d minus not following data0");
  rx_route_a: assert property (uartActive && dataOe[UART_RX_DATA_BIT] |->
    dataOut[UART_RX_DATA_BIT] == $past(dpIn, 3))
    else $error("data1 not following d plus");
  route_needs_uart_a: assert property (dmOe || (dataOe[1] && !dir) |-> uartActive)
    else $error("route driven outside uart mode");
  dir_pair_a: assert property ($rose(dir) |=> dir ##1 !dir)
    else $error("phy bus ownership not two cycles");
  nxt_shape_a: assert property ($rose(nxt) |=> (nxt ^ dir) ##1 !nxt)
    else $error("register access handshake broken");
endmodule : ulpi_regs_checker

bind ulpi_phy_latch_debug_uart_regs ulpi_regs_checker chk_u (.clk, .rst_b, .chipSel, .stp,
  .dataIn, .dataOut, .dataOe, .dir, .nxt, .dpIn, .dmOut, .dmOe, .uartSelect, .uartActive);
